// ==== common/ocpwm_map.svh ====
// Register offsets, field positions, reset values and codes of the compare/PWM channel
`ifndef OCPWM_MAP_SVH
`define OCPWM_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OCPWM_OFS_CON1     12'h000
`define OCPWM_OFS_CON2     12'h004
`define OCPWM_OFS_PRI      12'h008
`define OCPWM_OFS_SEC      12'h00c
`define OCPWM_OFS_TBPER    12'h010
`define OCPWM_OFS_CNT      12'h014
`define OCPWM_OFS_STAT     12'h018
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OCPWM_C1_TSEL_HI   12
`define OCPWM_C1_TSEL_LO   10
`define OCPWM_C1_TCLR      3
`define OCPWM_C1_MODE_HI   2
`define OCPWM_C2_CASC      8
`define OCPWM_C2_TRIG      7
`define OCPWM_C2_TSTAT     6
`define OCPWM_C2_TRIS      5
`define OCPWM_C2_SSEL_HI   4
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define OCPWM_RST_CON1     16'h0000
`define OCPWM_RST_CON2     16'h0000
`define OCPWM_RST_CMP      16'h0000
`define OCPWM_RST_TBPER    16'hffff
`define OCPWM_CNT_MAX      16'hffff
`define OCPWM_CNT_ZERO     16'h0000
`define OCPWM_SSEL_FREE    5'h00
`define OCPWM_SSEL_SELF    5'h1f
`define OCPWM_TSEL_SYSCLK  3'h7
`define OCPWM_TSEL_NTIMER  3'h5
`endif

// ==== common/ocpwm_pkg.sv ====
// Types of the compare/PWM channel
package ocpwm_pkg;
  typedef enum logic [2:0] {
    OCPWM_OFF      = 3'b000,
    OCPWM_SS_HIGH  = 3'b001,
    OCPWM_SS_LOW   = 3'b010,
    OCPWM_TOGGLE   = 3'b011,
    OCPWM_DBL_ONE  = 3'b100,
    OCPWM_DBL_CONT = 3'b101,
    OCPWM_PWM_EDGE = 3'b110,
    OCPWM_PWM_CTR  = 3'b111
  } ocpwm_mode_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } ocpwm_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ocpwm_apb_rsp_t;
endpackage

// ==== verilog/ocpwm_unit.sv ====
// Output compare / PWM channel with dedicated 16-bit counter and APB registers
//
// Operation
// - Counter counts up on selected clock, wraps from maximum to zero.
// - Compare event when counter equals primary or secondary compare register.
// - Sync source select zero, the default, means free-running operation.
// - Nonzero source enables sync/trigger; trigger select bit picks trigger mode.
// - Sync mode runs at once; each sync event resets the counter.
// - Trigger mode holds the counter until a trigger event arrives.
// - Cascade: odd channel is low half, its wrap increments even channel.
// - Compare modes hold default level, flip on primary match.
// - Double compare modes return to default on secondary match.
// - Flag on primary match in single, secondary match in double modes.
// - Single-shot fires once, rearmed by control one write; continuous repeats.
// - Toggle mode inverts the pin on every primary match.
// - Edge or center PWM; primary and secondary compare values pass through hidden buffers.
// - Three-bit time base select picks one of six counter clocks.
// - Three-bit mode field selects compare or PWM behaviour.
// - Mode encodings: 111 center, 110 edge, 101/100 double, 011 toggle, 000 off.
// - New duty values load when the period completes or after a control one write.
// - Period value N gives N plus one counts in self-sync mode.
// - Secondary above period keeps PWM output high all period.
//
// Chosen here: register access over APB and the register addresses.
`include "ocpwm_map.svh"
`timescale 1ns/10ps
`default_nettype none
module ocpwm_unit #(
  parameter bit CHAN_EVEN = 1'b0
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire ocpwm_pkg::ocpwm_apb_req_t apb_req,
  output ocpwm_pkg::ocpwm_apb_rsp_t      apb_rsp,
  input  wire logic [4:0]                tb_tick,
  input  wire logic [31:0]               sync_evt,
  input  wire logic                      casc_carry_in,
  output logic                           casc_carry_out,
  output logic                           oc_out,
  output logic                           oc_oe_n,
  output logic                           channel_interrupt_flag
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0]            control_reg_one_ff;
  logic [15:0]            control_reg_two_ff;
  logic [15:0]            primary_compare_reg_ff;
  logic [15:0]            secondary_compare_reg_ff;
  logic [15:0]            time_base_period_reg_ff;
  logic [15:0]            channel_counter_ff;
  logic [15:0]            duty_buf_ff;
  logic [15:0]            sec_buf_ff;
  logic                   pin_ff;
  logic                   armed_ff;
  logic                   restart_ff;
  logic                   irq_ff;
  logic [31:0]            rdata_ff;
  logic [15:0]            nxt_cnt;
  logic                   wr_en;
  logic                   rd_en;
  logic                   addr_ok;
  logic [15:0]            wmask;
  ocpwm_pkg::ocpwm_mode_t operating_mode_field;
  logic [2:0]             time_base_select;
  logic [4:0]             sync_source_select;
  logic                   trigger_select_bit;
  logic                   trigger_status;
  logic                   trigger_clear_mode;
  logic                   cascade_enable;
  logic                   pin_tristate_bit;
  logic                   tick;
  logic                   cnt_en;
  logic                   sync_mode;
  logic                   trig_mode;
  logic                   hold;
  logic                   is_pwm;
  logic [15:0]            pri_cmp;
  logic [15:0]            sec_cmp;
  logic [15:0]            period_val;
  logic                   pend;
  logic                   match_pri;
  logic                   match_sec;
  logic                   sync_hit;
  logic                   full_duty;
  logic                   init_lvl;

  assign operating_mode_field = ocpwm_pkg::ocpwm_mode_t'(
    control_reg_one_ff[`OCPWM_C1_MODE_HI:0]);
  assign time_base_select   = control_reg_one_ff[`OCPWM_C1_TSEL_HI:`OCPWM_C1_TSEL_LO];
  assign trigger_clear_mode = control_reg_one_ff[`OCPWM_C1_TCLR];
  assign sync_source_select = control_reg_two_ff[`OCPWM_C2_SSEL_HI:0];
  assign trigger_select_bit = control_reg_two_ff[`OCPWM_C2_TRIG];
  assign trigger_status     = control_reg_two_ff[`OCPWM_C2_TSTAT];
  assign cascade_enable     = control_reg_two_ff[`OCPWM_C2_CASC];
  assign pin_tristate_bit   = control_reg_two_ff[`OCPWM_C2_TRIS];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_en = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign wmask = {{8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};
  always_comb begin
    case (apb_req.paddr)
      `OCPWM_OFS_CON1, `OCPWM_OFS_CON2, `OCPWM_OFS_PRI, `OCPWM_OFS_SEC,
      `OCPWM_OFS_TBPER, `OCPWM_OFS_CNT, `OCPWM_OFS_STAT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
  assign apb_rsp.prdata  = rdata_ff;

  // Read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      case (apb_req.paddr)
        `OCPWM_OFS_CON1:  rdata_ff <= {16'h0000, control_reg_one_ff};
        `OCPWM_OFS_CON2:  rdata_ff <= {16'h0000, control_reg_two_ff};
        `OCPWM_OFS_PRI:   rdata_ff <= {16'h0000, primary_compare_reg_ff};
        `OCPWM_OFS_SEC:   rdata_ff <= {16'h0000, secondary_compare_reg_ff};
        `OCPWM_OFS_TBPER: rdata_ff <= {16'h0000, time_base_period_reg_ff};
        `OCPWM_OFS_CNT:   rdata_ff <= {16'h0000, channel_counter_ff};
        `OCPWM_OFS_STAT:  rdata_ff <= {29'h0, irq_ff, armed_ff, pin_ff};
        default:          rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Control one, compare and period registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_reg_one_ff       <= `OCPWM_RST_CON1;
      primary_compare_reg_ff   <= `OCPWM_RST_CMP;
      secondary_compare_reg_ff <= `OCPWM_RST_CMP;
      time_base_period_reg_ff  <= `OCPWM_RST_TBPER;
    end else if (wr_en) begin
      case (apb_req.paddr)
        `OCPWM_OFS_CON1:
          control_reg_one_ff <= (control_reg_one_ff & ~wmask) | (apb_req.pwdata[15:0] & wmask);
        `OCPWM_OFS_PRI:
          primary_compare_reg_ff <= (primary_compare_reg_ff & ~wmask)
                                    | (apb_req.pwdata[15:0] & wmask);
        `OCPWM_OFS_SEC:
          secondary_compare_reg_ff <= (secondary_compare_reg_ff & ~wmask)
                                      | (apb_req.pwdata[15:0] & wmask);
        `OCPWM_OFS_TBPER:
          time_base_period_reg_ff <= (time_base_period_reg_ff & ~wmask)
                                     | (apb_req.pwdata[15:0] & wmask);
        default: ;
      endcase
    end
  end

  // Control two; trigger status set by hardware wins over any clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_reg_two_ff <= `OCPWM_RST_CON2;
    end else begin
      if (wr_en && apb_req.paddr == `OCPWM_OFS_CON2) begin
        control_reg_two_ff <= (control_reg_two_ff & ~wmask) | (apb_req.pwdata[15:0] & wmask);
      end else if (trig_mode && trigger_status && trigger_clear_mode && match_sec) begin
        control_reg_two_ff[`OCPWM_C2_TSTAT] <= 1'b0;
      end
      if (trig_mode && sync_hit) begin
        control_reg_two_ff[`OCPWM_C2_TSTAT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Time base and counter
  // ----------------------------------------
  always_comb begin
    if (time_base_select == `OCPWM_TSEL_SYSCLK) begin
      tick = 1'b1;
    end else if (time_base_select < `OCPWM_TSEL_NTIMER) begin
      tick = tb_tick[time_base_select];
    end else begin
      tick = 1'b0;
    end
  end
  assign cnt_en    = (CHAN_EVEN && cascade_enable) ? casc_carry_in : tick;
  assign sync_mode = (sync_source_select != `OCPWM_SSEL_FREE) & ~trigger_select_bit;
  assign trig_mode = (sync_source_select != `OCPWM_SSEL_FREE) & trigger_select_bit;
  assign hold      = trig_mode & ~trigger_status;
  assign is_pwm    = operating_mode_field == ocpwm_pkg::OCPWM_PWM_EDGE
                   | operating_mode_field == ocpwm_pkg::OCPWM_PWM_CTR;
  assign pri_cmp   = is_pwm ? duty_buf_ff : primary_compare_reg_ff;
  assign sec_cmp   = is_pwm ? sec_buf_ff : secondary_compare_reg_ff;
  assign period_val = (sync_source_select == `OCPWM_SSEL_SELF) ? sec_cmp
                                                               : time_base_period_reg_ff;
  assign pend      = cnt_en & (channel_counter_ff == period_val);
  assign match_pri = cnt_en & (channel_counter_ff == pri_cmp);
  assign match_sec = cnt_en & (channel_counter_ff == sec_cmp);
  assign sync_hit  = (sync_source_select == `OCPWM_SSEL_SELF) ? pend
                                                              : sync_evt[sync_source_select];
  assign full_duty = sec_buf_ff > period_val;
  assign init_lvl  = operating_mode_field == ocpwm_pkg::OCPWM_SS_LOW;

  always_comb begin
    if (operating_mode_field == ocpwm_pkg::OCPWM_OFF || hold) begin
      nxt_cnt = `OCPWM_CNT_ZERO;
    end else if (sync_mode && sync_hit) begin
      nxt_cnt = `OCPWM_CNT_ZERO;
    end else if (cnt_en) begin
      nxt_cnt = channel_counter_ff + 16'h0001;
    end else begin
      nxt_cnt = channel_counter_ff;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_counter_ff <= `OCPWM_CNT_ZERO;
    end else begin
      channel_counter_ff <= nxt_cnt;
    end
  end
  assign casc_carry_out = cnt_en & ~hold & (channel_counter_ff == `OCPWM_CNT_MAX)
                        & ~(sync_mode & sync_hit);

  // ----------------------------------------
  // PWM double buffers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      duty_buf_ff <= `OCPWM_RST_CMP;
      sec_buf_ff  <= `OCPWM_RST_CMP;
    end else if (pend || !is_pwm || restart_ff) begin
      duty_buf_ff <= primary_compare_reg_ff;
      sec_buf_ff  <= secondary_compare_reg_ff;
    end
  end

  // ----------------------------------------
  // Output state machine
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= (wr_en && apb_req.paddr == `OCPWM_OFS_CON1) | (restart_ff & ~cnt_en);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_ff   <= 1'b0;
      armed_ff <= 1'b1;
    end else if (operating_mode_field == ocpwm_pkg::OCPWM_OFF || hold) begin
      pin_ff   <= init_lvl;
      armed_ff <= 1'b1;
    end else if (restart_ff && cnt_en) begin
      pin_ff   <= init_lvl;
      armed_ff <= 1'b1;
    end else if (cnt_en) begin
      case (operating_mode_field)
        ocpwm_pkg::OCPWM_SS_HIGH, ocpwm_pkg::OCPWM_SS_LOW: begin
          if (match_pri && armed_ff) begin
            pin_ff   <= ~init_lvl;
            armed_ff <= 1'b0;
          end
        end
        ocpwm_pkg::OCPWM_TOGGLE: begin
          if (match_pri) begin
            pin_ff <= ~pin_ff;
          end
        end
        ocpwm_pkg::OCPWM_DBL_ONE, ocpwm_pkg::OCPWM_DBL_CONT: begin
          if (match_sec && armed_ff) begin
            pin_ff   <= 1'b0;
            armed_ff <= operating_mode_field == ocpwm_pkg::OCPWM_DBL_CONT;
          end else if (match_pri && armed_ff) begin
            pin_ff <= 1'b1;
          end
        end
        ocpwm_pkg::OCPWM_PWM_EDGE: begin
          if (full_duty) begin
            pin_ff <= 1'b1;
          end else if (pend) begin
            pin_ff <= primary_compare_reg_ff != `OCPWM_CNT_ZERO;
          end else if (match_pri) begin
            pin_ff <= 1'b0;
          end
        end
        ocpwm_pkg::OCPWM_PWM_CTR: begin
          if (full_duty) begin
            pin_ff <= 1'b1;
          end else if (match_sec) begin
            pin_ff <= 1'b0;
          end else if (match_pri) begin
            pin_ff <= 1'b1;
          end
        end
        default: pin_ff <= init_lvl;
      endcase
    end
  end

  // Interrupt flag pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      case (operating_mode_field)
        ocpwm_pkg::OCPWM_SS_HIGH, ocpwm_pkg::OCPWM_SS_LOW, ocpwm_pkg::OCPWM_TOGGLE:
          irq_ff <= match_pri & armed_ff & ~hold & ~restart_ff;
        ocpwm_pkg::OCPWM_DBL_ONE, ocpwm_pkg::OCPWM_DBL_CONT:
          irq_ff <= match_sec & armed_ff & ~hold & ~restart_ff;
        default: irq_ff <= 1'b0;
      endcase
    end
  end

  assign oc_out                 = pin_ff;
  assign oc_oe_n                = pin_tristate_bit;
  assign channel_interrupt_flag = irq_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  cnt_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (operating_mode_field != ocpwm_pkg::OCPWM_OFF && !hold && !(sync_mode && sync_hit)
     && cnt_en && channel_counter_ff == `OCPWM_CNT_MAX) |=> channel_counter_ff == 16'h0000)
    else $error("counter did not wrap to zero");
  hold_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    hold |=> channel_counter_ff == 16'h0000 && pin_ff == $past(init_lvl))
    else $error("counter or pin not held while waiting for trigger");
  trig_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (trig_mode && sync_hit) |=> trigger_status)
    else $error("trigger event did not start the counter");
  sync_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_mode && sync_hit && operating_mode_field != ocpwm_pkg::OCPWM_OFF)
    |=> channel_counter_ff == 16'h0000)
    else $error("sync event did not reset counter");
  irq_single_a: assert property (@(posedge clk) disable iff (!rst_n)
    (operating_mode_field == ocpwm_pkg::OCPWM_SS_HIGH && match_pri && armed_ff && !restart_ff
     && !hold) |=> channel_interrupt_flag ##1 !channel_interrupt_flag || $past(match_pri))
    else $error("flag missing after primary match");
  toggle_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    (operating_mode_field == ocpwm_pkg::OCPWM_TOGGLE && match_pri && !hold && !restart_ff)
    |=> pin_ff != $past(pin_ff))
    else $error("toggle mode did not invert pin");
  dbl_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    (operating_mode_field == ocpwm_pkg::OCPWM_DBL_CONT && match_sec && armed_ff
     && !hold && !restart_ff) |=> !pin_ff)
    else $error("double compare did not return pin low");
  duty_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_pwm && !pend && !restart_ff) |=> $stable(duty_buf_ff))
    else $error("duty buffer changed inside a period");
  full_duty_a: assert property (@(posedge clk) disable iff (!rst_n)
    (operating_mode_field == ocpwm_pkg::OCPWM_PWM_EDGE && full_duty && cnt_en
     && !hold && !restart_ff) |=> pin_ff)
    else $error("full duty did not keep pin high");
endmodule
`default_nettype wire

// ==== bench/ocpwm_load.sv ====
// Load model on the compare output pin, measures pulse widths
`timescale 1ns/10ps
`default_nettype none
module ocpwm_load (
  input  wire logic        clk,
  input  wire logic        pin,
  input  wire logic        oe_n,
  output logic [15:0]      hi_len,
  output logic [15:0]      per_len,
  output logic [15:0]      falls
);
  logic        lvl;
  logic        lvl_ff;
  logic [15:0] hi_ff;
  logic [15:0] per_ff;
  // ----------------------------------------
  // Node level and width counters
  // ----------------------------------------
  // Pull-down holds the node low while the pin floats
  assign lvl = oe_n ? 1'b0 : pin;
  initial begin
    {lvl_ff, hi_ff, per_ff, hi_len, per_len, falls} = '0;
  end
  always @(posedge clk) begin
    lvl_ff <= lvl;
    hi_ff  <= lvl ? hi_ff + 16'h0001 : 16'h0000;
    per_ff <= (lvl && !lvl_ff) ? 16'h0001 : per_ff + 16'h0001;
    if (lvl && !lvl_ff)
      per_len <= per_ff;
    if (!lvl && lvl_ff)
      hi_len <= hi_ff;
    if (!lvl && lvl_ff)
      falls <= falls + 16'h0001;
  end
endmodule
`default_nettype wire

// ==== bench/tb_output_compare_pwm_unit.sv ====
// Self-checking bench of the compare/PWM channel
`timescale 1ns/10ps
`default_nettype none
module tb_output_compare_pwm_unit;
  logic                      clk;
  logic                      rst_n;
  ocpwm_pkg::ocpwm_apb_req_t req;
  ocpwm_pkg::ocpwm_apb_rsp_t rsp;
  ocpwm_pkg::ocpwm_apb_rsp_t rsp_e;
  logic                      pick_e = 1'b0;
  logic [4:0]                tb_tick;
  logic [31:0]               sync_evt;
  logic                      carry_out;
  logic                      pin;
  logic                      oe_n;
  logic                      flag;
  logic                      err;
  logic [15:0]               a;
  logic [15:0]               f0;
  logic [15:0]               n0;
  logic [15:0]               hi_len;
  logic [15:0]               per_len;
  logic [15:0]               falls;
  logic [15:0]               flags = 16'h0000;
  logic [15:0]               carries = 16'h0000;
  int                        mismatches = 0;
  int                        checked = 0;
  int                        cyc = 0;
  logic [2:0]                ts [7] = '{0, 1, 2, 3, 4, 5, 7};
  logic [15:0]               te [7] = '{30, 20, 15, 12, 10, 0, 60};
  logic [15:0]               tbl [4][5] = '{'{3, 2, 4, 5, 10}, '{5, 2, 6, 4, 7},
                                            '{7, 2, 9, 7, 10}, '{6, 3, 9, 4, 10}};
  ocpwm_unit dut (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .apb_req                (req),
    .apb_rsp                (rsp),
    .tb_tick                (tb_tick),
    .sync_evt               (sync_evt),
    .casc_carry_in          (1'b0),
    .casc_carry_out         (carry_out),
    .oc_out                 (pin),
    .oc_oe_n                (oe_n),
    .channel_interrupt_flag (flag)
  );
  // Even half of a cascaded pair, counting the carries of dut
  ocpwm_unit #(.CHAN_EVEN(1'b1)) dut_even (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .apb_req                (req),
    .apb_rsp                (rsp_e),
    .tb_tick                (tb_tick),
    .sync_evt               (sync_evt),
    .casc_carry_in          (carry_out),
    .casc_carry_out         (),
    .oc_out                 (),
    .oc_oe_n                (),
    .channel_interrupt_flag ()
  );
  ocpwm_load load (.clk(clk), .pin(pin), .oe_n(oe_n), .hi_len(hi_len), .per_len(per_len),
                   .falls(falls));
  // ----------------------------------------
  // Clock, event counters and bus tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    // Tick k comes once every k plus two cycles
    for (int k = 0; k < 5; k++)
      tb_tick[k] <= (cyc % (k + 2)) == 0;
    flags   <= flags + {15'h0000, flag === 1'b1};
    carries <= carries + {15'h0000, carry_out === 1'b1};
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [15:0] d,
                     output logic [15:0] q);
    req <= '{1'b1, 1'b0, w, ad, {16'h0000, d}, 4'hf};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1)
      @(posedge clk);
    q = pick_e ? rsp_e.prdata[15:0] : rsp.prdata[15:0];
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [15:0] d);
    apb(1'b1, ad, d, a);
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [15:0] e, input string nm);
    apb(1'b0, ad, 16'h0000, a);
    cmp(nm, e, a);
  endtask
  task automatic pulse(input int i);
    sync_evt <= 32'h0000_0001 << i;
    @(posedge clk);
    sync_evt <= '0;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_n, sync_evt, err} = '0;
    req = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(12'h000, 16'h0000, "con1");
    rdc(12'h004, 16'h0000, "con2");
    rdc(12'h010, 16'hffff, "tbper");
    rdc(12'h01c, 16'h0000, "unmapped");
    cmp("slverr", 16'h0001, {15'h0000, err});
    wr(12'h014, 16'h1234);
    rdc(12'h014, 16'h0000, "cnt_off");
    $display("test 1 done");
    wr(12'h008, 16'hffff);
    for (int i = 0; i < 7; i++) begin
      wr(12'h000, {3'h0, ts[i], 7'h00, 3'h1});
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h014, 16'h0000, f0);
      repeat (57) @(posedge clk);
      rdc(12'h014, te[i] + f0, "tick_count");
    end
    $display("test 2 done");
    wr(12'h000, 16'h1c01);
    repeat (200) @(posedge clk);
    pulse(3);
    apb(1'b0, 12'h014, 16'h0000, f0);
    cmp("free_run", 16'h0001, {15'h0000, f0 > 16'd100});
    wr(12'h004, 16'h0003);
    pulse(3);
    apb(1'b0, 12'h014, 16'h0000, f0);
    cmp("sync_reset", 16'h0001, {15'h0000, f0 < 16'd8});
    $display("test 3 done");
    wr(12'h008, 16'h0003);
    wr(12'h004, 16'h0083);
    wr(12'h000, 16'h1c01);
    repeat (10) @(posedge clk);
    rdc(12'h014, 16'h0000, "trig_hold");
    cmp("trig_pin", 16'h0000, {15'h0000, pin});
    pulse(3);
    repeat (20) @(posedge clk);
    cmp("trig_run", 16'h0001, {15'h0000, pin});
    wr(12'h00c, 16'h0040);
    wr(12'h000, 16'h1c09);
    repeat (80) @(posedge clk);
    rdc(12'h004, 16'h0083, "trig_clear");
    rdc(12'h014, 16'h0000, "trig_rehold");
    $display("test 4 done");
    wr(12'h004, 16'h0100);
    wr(12'h000, 16'h1c00);
    wr(12'h000, 16'h1c01);
    f0 = flags;
    n0 = carries;
    repeat (65600) @(posedge clk);
    cmp("single_flags", 16'h0001, flags - f0);
    cmp("single_pin", 16'h0001, {15'h0000, pin});
    cmp("wraps", 16'h0001, carries - n0);
    pick_e = 1'b1;
    rdc(12'h014, 16'h0001, "casc_high");
    pick_e = 1'b0;
    wr(12'h000, 16'h1c01);
    repeat (4) @(posedge clk);
    cmp("restart_pin", 16'h0000, {15'h0000, pin});
    wr(12'h000, 16'h1c00);
    wr(12'h000, 16'h1c01);
    repeat (20) @(posedge clk);
    cmp("rearm_flags", 16'h0002, flags - f0);
    $display("test 5 done");
    wr(12'h004, 16'h001f);
    wr(12'h010, 16'h0009);
    rdc(12'h010, 16'h0009, "tbper_wr");
    for (int i = 0; i < 4; i++) begin
      // Switching off first starts every waveform from a zero counter
      wr(12'h000, 16'h1c00);
      wr(12'h008, tbl[i][1]);
      wr(12'h00c, tbl[i][2]);
      wr(12'h000, 16'h1c00 | tbl[i][0]);
      repeat (60) @(posedge clk);
      f0 = flags;
      n0 = falls;
      repeat (70) @(posedge clk);
      cmp("high_len", tbl[i][3], hi_len);
      cmp("period_len", tbl[i][4], per_len);
      if (tbl[i][0] == 16'h0005)
        cmp("flag_per_fall", falls - n0, flags - f0);
    end
    wr(12'h008, 16'h0006);
    repeat (40) @(posedge clk);
    cmp("new_duty", 16'h0007, hi_len);
    wr(12'h004, 16'h003f);
    cmp("tristate", 16'h0001, {15'h0000, oe_n});
    $display("test 6 done");
    give_verdict();
  end
endmodule
`default_nettype wire
